// ===== dcfc_ana_model.sv
// behavioural model of the two analog comparator cores
`timescale 1ns/1ps
module dcfc_ana_model
   import dcfc_pkg::*;
#(
   parameter logic [11:0] VREF_MV = 12'h4CE
)
(
   // clock for the idle pattern
   input wire logic mclk,
   // control and levels in millivolts
   input dcfc_ana_ctl_t [1:0] ana_ctl,
   input wire logic [1:0][11:0] pos_a,
   input wire logic [1:0][11:0] pos_b,
   input wire logic [1:0][11:0] neg_pin,
   // results
   output logic [1:0] cmp_raw
);
   logic tgl = 1'b0;
   always @(posedge mclk) begin
      tgl <= ~tgl;
   end
   // a stopped core shows a changing pattern, not its last value
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         if (!ana_ctl[i].en) begin
            cmp_raw[i] = tgl;
         end else begin
            cmp_raw[i] = (ana_ctl[i].psel ? pos_b[i] : pos_a[i])
               > (ana_ctl[i].nref ? VREF_MV : neg_pin[i]);
         end
      end
   end
endmodule

// ===== dcfc_pkg.sv
// package: register map, field layout and shared types for the comparator block
package dcfc_pkg;
   // ==========================================
   // register offsets (byte addresses)
   localparam logic [3:0] DCFC_OFS_CFG0 = 4'h0;
   localparam logic [3:0] DCFC_OFS_CFG1 = 4'h4;
   localparam logic [3:0] DCFC_OFS_PWR = 4'h8;
   localparam logic [3:0] DCFC_OFS_STAT = 4'hC;
   // ==========================================
   // config register fields
   localparam int DCFC_B_EN = 0;
   localparam int DCFC_B_PSEL = 1;
   localparam int DCFC_B_NREF = 2;
   localparam int DCFC_B_OE = 3;
   localparam int DCFC_B_IE = 4;
   localparam int DCFC_B_OUT = 5;
   localparam int DCFC_B_FLAG = 6;
   // power control bit that shuts both comparators
   localparam int DCFC_B_PWR_OFF = 5;
   localparam int DCFC_B_TPD = 0;
   localparam logic [31:0] DCFC_CFG_RST = 32'h0000_0000;
   localparam logic [7:0] DCFC_PWR_RST = 8'h00;
   // ==========================================
   // analog side of one comparator
   typedef struct packed {
      logic en;
      logic psel;
      logic nref;
   } dcfc_ana_ctl_t;
endpackage

// ===== dcfc_sync.sv
// two-flop synchroniser for a comparator output
`timescale 1ns/1ps
module dcfc_sync
   import dcfc_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // data
   input wire logic d,
   output logic q
);
   logic meta_q;

   always_ff @(posedge mclk) begin
      if (srst) begin
         meta_q <= 1'b1;
         q <= 1'b1;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// ===== dcfc_top.sv
// dual comparator control, change flags, interrupt and wake logic
//
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
// Function
// RULE1 - output one when positive exceeds negative
// RULE2 - selectable positive pin, negative pin or reference
// RULE3 - output readable, optionally driven to pin
// RULE4 - change flag set on every output edge
// RULE5 - flag pollable, interrupt when enabled
// RULE6 - both requests share one interrupt line
// RULE7 - software waits 10 us after enable
// RULE8 - disabled comparator output forced high
// RULE9 - forced rise sets flag, may interrupt
// RULE10 - software masks before disable, clears after
// RULE11 - comparators keep running in idle, power-down
// RULE12 - total power-down disables both comparators
// RULE13 - enabled change wakes processor from sleep
// RULE14 - power control bit five disables both
// RULE15 - software picks push-pull for routed output
// RULE16 - two-flop sync, asynchronous wake detector
module dcfc_top
   import dcfc_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // avalon-mm slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // analog cores
   input wire logic [1:0] cmp_raw,
   output dcfc_ana_ctl_t [1:0] ana_ctl,
   // pins and system
   output logic [1:0] comparator_output_pin,
   output logic [1:0] comparator_output_pin_oe,
   input wire logic idle_mode,
   input wire logic pdown_mode,
   output logic irq,
   output logic wake
);
   // ==========================================
   // state
   logic [1:0] en_q, psel_q, nref_q, oe_q, ie_q;
   logic [1:0] comparator_change_flag_q;
   logic [1:0] out_q;
   logic [1:0] out_prev_q;
   logic [1:0] sync_out;
   logic [1:0] run;
   logic [1:0] wake_req;
   logic [7:0] power_control_a_q;
   logic ack_q;
   logic [1:0] flag_set;
   logic [1:0] flag_clr;
   logic wr_hit, rd_hit;

   // ==========================================
   // bus handshake: one wait cycle then accept
   assign wr_hit = avs_write && ack_q;
   assign rd_hit = avs_read && ack_q;

   always_ff @(posedge mclk) begin
      if (srst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read || avs_write) && !ack_q;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
      end
   end

   // ==========================================
   // power control register
   always_ff @(posedge mclk) begin
      if (srst) begin
         power_control_a_q <= DCFC_PWR_RST;
      end else if (wr_hit && avs_address == DCFC_OFS_PWR && avs_byteenable[0]) begin
         power_control_a_q <= avs_writedata[7:0]; // RULE14
      end
   end

   // ==========================================
   // per-comparator logic
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_cmp
         localparam logic [3:0] OFS = (gi == 0) ? DCFC_OFS_CFG0 : DCFC_OFS_CFG1;
         logic cfg_wr;
         assign cfg_wr = wr_hit && avs_address == OFS && avs_byteenable[0];

         always_ff @(posedge mclk) begin
            if (srst) begin
               en_q[gi] <= 1'b0;
               psel_q[gi] <= 1'b0;
               nref_q[gi] <= 1'b0;
               oe_q[gi] <= 1'b0;
               ie_q[gi] <= 1'b0;
            end else if (cfg_wr) begin
               en_q[gi] <= avs_writedata[DCFC_B_EN];
               psel_q[gi] <= avs_writedata[DCFC_B_PSEL]; // RULE2
               nref_q[gi] <= avs_writedata[DCFC_B_NREF]; // RULE2
               oe_q[gi] <= avs_writedata[DCFC_B_OE];
               ie_q[gi] <= avs_writedata[DCFC_B_IE];
            end
         end

         // run unless shut by power bit or total power-down
         assign run[gi] = en_q[gi] && !power_control_a_q[DCFC_B_PWR_OFF] // RULE14
                          && !power_control_a_q[DCFC_B_TPD]; // RULE12 RULE11

         always_ff @(posedge mclk) begin
            if (srst) begin
               ana_ctl[gi] <= '0;
            end else begin
               ana_ctl[gi] <= '{en: run[gi], psel: psel_q[gi], nref: nref_q[gi]}; // RULE2
            end
         end

         dcfc_sync u_sync (
            .mclk(mclk),
            .srst(srst),
            .d(cmp_raw[gi]),
            .q(sync_out[gi])
         ); // RULE16

         always_ff @(posedge mclk) begin
            if (srst) begin
               out_q[gi] <= 1'b1;
               out_prev_q[gi] <= 1'b1;
            end else begin
               out_q[gi] <= run[gi] ? sync_out[gi] : 1'b1; // RULE1 RULE8
               out_prev_q[gi] <= out_q[gi];
            end
         end

         assign flag_set[gi] = out_q[gi] != out_prev_q[gi]; // RULE4 RULE9
         assign flag_clr[gi] = cfg_wr && avs_writedata[DCFC_B_FLAG];

         // write one clears; a same-cycle edge wins
         always_ff @(posedge mclk) begin
            if (srst) begin
               comparator_change_flag_q[gi] <= 1'b0;
            end else if (flag_set[gi]) begin
               comparator_change_flag_q[gi] <= 1'b1; // RULE4
            end else if (flag_clr[gi]) begin
               comparator_change_flag_q[gi] <= 1'b0;
            end
         end

         always_ff @(posedge mclk) begin
            if (srst) begin
               comparator_output_pin[gi] <= 1'b1;
               comparator_output_pin_oe[gi] <= 1'b0;
            end else begin
               comparator_output_pin[gi] <= out_q[gi]; // RULE3
               comparator_output_pin_oe[gi] <= oe_q[gi]; // RULE3 RULE15
            end
         end

         dcfc_wake u_wake (
            .mclk(mclk),
            .srst(srst),
            .arm(run[gi] && ie_q[gi] && pdown_mode),
            .raw(cmp_raw[gi]),
            .ref_lvl(out_q[gi]),
            .wake(wake_req[gi])
         ); // RULE16 RULE13
      end
   endgenerate

   // ==========================================
   // interrupt and wake outputs
   always_ff @(posedge mclk) begin
      if (srst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(comparator_change_flag_q & ie_q); // RULE5 RULE6
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         wake <= 1'b0;
      end else begin
         wake <= ((idle_mode || pdown_mode) && |(comparator_change_flag_q & ie_q))
                 || |wake_req; // RULE13
      end
   end

   // ==========================================
   // read data
   function automatic logic [31:0] cfg_word(input int i);
      logic [31:0] w;
      w = DCFC_CFG_RST;
      w[DCFC_B_EN] = en_q[i];
      w[DCFC_B_PSEL] = psel_q[i];
      w[DCFC_B_NREF] = nref_q[i];
      w[DCFC_B_OE] = oe_q[i];
      w[DCFC_B_IE] = ie_q[i];
      w[DCFC_B_OUT] = out_q[i];
      w[DCFC_B_FLAG] = comparator_change_flag_q[i];
      return w;
   endfunction

   always_ff @(posedge mclk) begin
      if (srst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (rd_hit || ((avs_read) && !ack_q)) begin
         unique case (avs_address)
            DCFC_OFS_CFG0: avs_readdata <= cfg_word(0); // RULE3 RULE5
            DCFC_OFS_CFG1: avs_readdata <= cfg_word(1);
            DCFC_OFS_PWR: avs_readdata <= {24'h00_0000, power_control_a_q};
            DCFC_OFS_STAT: avs_readdata <= {28'h000_0000, comparator_change_flag_q, out_q};
            default: avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================
   // checks
   flag_on_edge_a: assert property (@(posedge mclk) disable iff (srst) // RULE4
      $changed(out_prev_q[0]) |-> comparator_change_flag_q[0])
      else $error("flag not set on output change");
   flag_second_a: assert property (@(posedge mclk) disable iff (srst) // RULE4
      $changed(out_prev_q[1]) |-> comparator_change_flag_q[1])
      else $error("second flag not set on output change");
   forced_high_a: assert property (@(posedge mclk) disable iff (srst) // RULE8
      !run[1] |=> out_q[1])
      else $error("disabled output not high");
   forced_first_a: assert property (@(posedge mclk) disable iff (srst) // RULE8
      !run[0] |=> out_q[0])
      else $error("disabled first output not high");
   pwr_off_a: assert property (@(posedge mclk) disable iff (srst) // RULE14
      power_control_a_q[DCFC_B_PWR_OFF] |=> !ana_ctl[0].en && !ana_ctl[1].en)
      else $error("power bit did not disable");
   tpd_off_a: assert property (@(posedge mclk) disable iff (srst) // RULE12
      power_control_a_q[DCFC_B_TPD] |=> !ana_ctl[0].en)
      else $error("total power-down left comparator on");
   tpd_second_a: assert property (@(posedge mclk) disable iff (srst) // RULE12
      power_control_a_q[DCFC_B_TPD] |=> !ana_ctl[1].en)
      else $error("total power-down left second comparator on");
   irq_level_a: assert property (@(posedge mclk) disable iff (srst) // RULE5
      |(comparator_change_flag_q & ie_q) |=> irq)
      else $error("interrupt missing");
   irq_drop_a: assert property (@(posedge mclk) disable iff (srst) // RULE5
      !(|(comparator_change_flag_q & ie_q)) |=> !irq)
      else $error("interrupt without enabled flag");
   irq_share_a: assert property (@(posedge mclk) disable iff (srst) // RULE6
      irq |-> $past(|(comparator_change_flag_q & ie_q)))
      else $error("spurious interrupt");
   out_follow_a: assert property (@(posedge mclk) disable iff (srst) // RULE1
      run[0] && $past(run[0]) |-> out_q[0] == $past(sync_out[0]))
      else $error("output does not follow compare");
   follow_second_a: assert property (@(posedge mclk) disable iff (srst) // RULE1
      run[1] && $past(run[1]) |-> out_q[1] == $past(sync_out[1]))
      else $error("second output does not follow compare");
   sel_pass_a: assert property (@(posedge mclk) disable iff (srst) // RULE2
      ana_ctl[0].psel == $past(psel_q[0]) && ana_ctl[0].nref == $past(nref_q[0]))
      else $error("input selection not passed on");
   pin_route_a: assert property (@(posedge mclk) disable iff (srst) // RULE3
      comparator_output_pin_oe[0] |-> comparator_output_pin[0] == $past(out_q[0]))
      else $error("pin not routed");
   oe_pass_a: assert property (@(posedge mclk) disable iff (srst) // RULE3
      comparator_output_pin_oe == $past(oe_q))
      else $error("pin enable not passed on");
   flag_hold_a: assert property (@(posedge mclk) disable iff (srst) // RULE5
      comparator_change_flag_q[0] && !flag_clr[0] |=> comparator_change_flag_q[0])
      else $error("flag lost without clear");
   sync_delay_a: assert property (@(posedge mclk) disable iff (srst) // RULE16
      run[0] ##1 run[0] ##1 run[0] |-> out_q[0] == $past(cmp_raw[0], 3))
      else $error("sync latency wrong");
   wake_idle_a: assert property (@(posedge mclk) disable iff (srst) // RULE13
      idle_mode && |(comparator_change_flag_q & ie_q) |=> wake)
      else $error("no wake");
   wake_pdown_a: assert property (@(posedge mclk) disable iff (srst) // RULE13
      pdown_mode && |(comparator_change_flag_q & ie_q) |=> wake)
      else $error("no wake in power-down");
   wake_async_a: assert property (@(posedge mclk) disable iff (srst) // RULE16
      |wake_req |=> wake)
      else $error("change detector did not wake");
   disable_rise_a: assert property (@(posedge mclk) disable iff (srst) // RULE9
      !out_q[1] ##1 !run[1] |-> ##[1:2] comparator_change_flag_q[1])
      else $error("disable rise did not flag");
   cfg_keep_a: assert property (@(posedge mclk) disable iff (srst) // RULE11
      idle_mode && en_q[0] && !power_control_a_q[DCFC_B_PWR_OFF]
      && !power_control_a_q[DCFC_B_TPD] |=> ana_ctl[0].en)
      else $error("idle stopped comparator");
   wait_one_a: assert property (@(posedge mclk) disable iff (srst)
      !avs_waitrequest |=> avs_waitrequest)
      else $error("wait request low for more than one cycle");
   cv_irq_c: cover property (@(posedge mclk) irq);
   cv_wake_c: cover property (@(posedge mclk) wake && pdown_mode);
   cv_both_c: cover property (@(posedge mclk) &comparator_change_flag_q);
   cv_forced_c: cover property (@(posedge mclk) !out_q[1] ##1 !run[1] ##2 comparator_change_flag_q[1]);
   cv_tpd_c: cover property (@(posedge mclk) en_q[0] && power_control_a_q[DCFC_B_TPD]);
endmodule

// ===== dcfc_wake.sv
// asynchronous change catcher that raises wake while the clock is stopped
`timescale 1ns/1ps
module dcfc_wake
   import dcfc_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // control
   input wire logic arm,
   input wire logic raw,
   input wire logic ref_lvl,
   // result
   output logic wake
);
   // level compare needs no clock: a mismatch with the last sampled level wakes
   logic mism_q;

   always_ff @(posedge mclk) begin
      if (srst) begin
         mism_q <= 1'b0;
      end else begin
         mism_q <= arm && (raw != ref_lvl);
      end
   end

   assign wake = arm && ((raw != ref_lvl) || mism_q);
endmodule

// ===== test_dual_comparator_flag_control.sv
// self-checking bench for the dual comparator flag control block
`timescale 1ns/1ps
module test_dual_comparator_flag_control
   import dcfc_pkg::*;
   ;
   // ==========================================
   // signals and instances
   logic mclk, srst, rd, wr, wreq, irq, wake, idle, pdn;
   logic [3:0] addr, be;
   logic [31:0] wdata, rdata, q;
   logic [1:0] raw, pin, pin_oe;
   logic [1:0][11:0] pa, pb, pn;
   dcfc_ana_ctl_t [1:0] ctl;
   int errors, total_checks;
   // settle time after enable, 10 us at 100 MHz
   localparam int SETTLE_CYC = 1000;
   dcfc_top u_dut (.mclk(mclk), .srst(srst), .avs_address(addr), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
      .avs_waitrequest(wreq), .cmp_raw(raw), .ana_ctl(ctl), .comparator_output_pin(pin),
      .comparator_output_pin_oe(pin_oe), .idle_mode(idle), .pdown_mode(pdn), .irq(irq),
      .wake(wake));
   dcfc_ana_model u_ana (.mclk(mclk), .ana_ctl(ctl), .pos_a(pa), .pos_b(pb), .neg_pin(pn),
      .cmp_raw(raw));
   // ==========================================
   // bus and compare tasks
   task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      rd <= !w;
      wr <= w;
      do begin
         @(posedge mclk);
      end while (wreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input string nm);
      av(1'b0, a, 32'h0);
      chk(nm, e, q);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // ==========================================
   // scenarios
   task automatic t_reset;
      rd_chk(DCFC_OFS_CFG0, 32'h20, "cfg0");
      rd_chk(DCFC_OFS_PWR, 32'h0, "pwr");
      rd_chk(DCFC_OFS_STAT, 32'h3, "stat");
      rd_chk(4'h1, 32'h0, "unmapped");
      chk("pins", 32'h3, {28'h0, pin_oe, pin});
   endtask
   task automatic t_compare;
      logic [11:0] ta[6] = '{12'h1F4, 12'h190, 12'h000, 12'h000, 12'h000, 12'h3E8};
      logic [11:0] tb[6] = '{12'h000, 12'h000, 12'h2BC, 12'h4CF, 12'h4CE, 12'h000};
      logic [11:0] tn[6] = '{12'h190, 12'h190, 12'h258, 12'h7D0, 12'h7D0, 12'h000};
      logic [1:0] tm[6] = '{2'h0, 2'h0, 2'h1, 2'h3, 2'h3, 2'h2};
      logic te[6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
      for (int c = 0; c < 2; c++) begin
         for (int i = 0; i < 6; i++) begin
            pa[c] <= ta[i];
            pb[c] <= tb[i];
            pn[c] <= tn[i];
            av(1'b1, c ? DCFC_OFS_CFG1 : DCFC_OFS_CFG0, {29'h0, tm[i], 1'b1});
            cyc(i == 0 ? SETTLE_CYC : 6);
            chk("ctl", {29'h0, 1'b1, tm[i][0], tm[i][1]}, {29'h0, ctl[c]});
            av(1'b0, DCFC_OFS_STAT, 32'h0);
            chk("out", {31'h0, te[i]}, {31'h0, q[c]});
         end
         av(1'b1, c ? DCFC_OFS_CFG1 : DCFC_OFS_CFG0, 32'h0);
         cyc(4);
         av(1'b1, c ? DCFC_OFS_CFG1 : DCFC_OFS_CFG0, 32'h40);
      end
   endtask
   task automatic t_flags;
      pa[1] <= 12'h1F4;
      pn[1] <= 12'h190;
      av(1'b1, DCFC_OFS_CFG1, 32'h09);
      cyc(SETTLE_CYC);
      av(1'b1, DCFC_OFS_CFG1, 32'h49);
      pn[1] <= 12'h258;
      cyc(6);
      rd_chk(DCFC_OFS_CFG1, 32'h49, "fall flag");
      chk("irq masked", 32'h0, {31'h0, irq});
      chk("pins", 32'h9, {28'h0, pin_oe, pin});
      av(1'b1, DCFC_OFS_CFG1, 32'h59);
      pn[1] <= 12'h190;
      cyc(6);
      chk("irq rise", 32'h1, {31'h0, irq});
      rd_chk(DCFC_OFS_STAT, 32'hB, "stat");
      av(1'b1, DCFC_OFS_CFG1, 32'h59);
      cyc(2);
      chk("irq clr", 32'h0, {31'h0, irq});
      pn[1] <= 12'h258;
      cyc(6);
      av(1'b1, DCFC_OFS_CFG1, 32'h59);
      av(1'b1, DCFC_OFS_CFG1, 32'h58);
      cyc(4);
      rd_chk(DCFC_OFS_CFG1, 32'h78, "forced");
      chk("irq forced", 32'h1, {31'h0, irq});
      av(1'b1, DCFC_OFS_CFG1, 32'h40);
   endtask
   task automatic t_power;
      logic w;
      w = 1'b0;
      pa[0] <= 12'h1F4;
      pn[0] <= 12'h190;
      av(1'b1, DCFC_OFS_CFG0, 32'h01);
      cyc(SETTLE_CYC);
      av(1'b1, DCFC_OFS_CFG0, 32'h51);
      idle <= 1'b1;
      pdn <= 1'b1;
      pn[0] <= 12'h258;
      for (int i = 0; i < 8; i++) begin
         @(posedge mclk);
         w = w | wake;
      end
      chk("wake", 32'h1, {31'h0, w});
      chk("irq first", 32'h1, {31'h0, irq});
      chk("en sleep", 32'h1, {31'h0, ctl[0].en});
      rd_chk(DCFC_OFS_STAT, 32'h6, "stat sleep");
      av(1'b1, DCFC_OFS_CFG0, 32'h41);
      idle <= 1'b0;
      pdn <= 1'b0;
      av(1'b1, DCFC_OFS_PWR, 32'h20);
      cyc(4);
      chk("en off", 32'h0, {31'h0, ctl[0].en});
      rd_chk(DCFC_OFS_STAT, 32'h7, "stat off");
      av(1'b1, DCFC_OFS_PWR, 32'h01);
      cyc(2);
      chk("en tpd", 32'h0, {31'h0, ctl[0].en});
      av(1'b1, DCFC_OFS_PWR, 32'h0);
      be <= 4'h0;
      av(1'b1, DCFC_OFS_CFG0, 32'h0);
      be <= 4'hF;
      av(1'b1, DCFC_OFS_STAT, 32'h0);
      av(1'b0, DCFC_OFS_CFG0, 32'h0);
      chk("cfg kept", 32'h1, {31'h0, q[0]});
   endtask
   // ==========================================
   // verdict, clock, sequence and watchdog
   task automatic print_verdict;
      if (errors == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      srst = 1'b1;
      {rd, wr, idle, pdn, pa, pb, pn, addr, wdata, errors, total_checks} = '0;
      be = 4'hF;
      repeat (6) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      t_reset();
      t_compare();
      t_flags();
      t_power();
      print_verdict();
   end
   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      print_verdict();
   end
endmodule
